/* gpio_pin_model.sv */
// Model of the outside world on the eight pins
`timescale 1ns/1ps
module gpio_pin_model
  import gpio_pkg::*;
(
  // Clock
  input  wire logic       ref_clk,
  // From the port
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe_n,
  input  wire logic [7:0] pinPullup,
  // Outside drivers and buffer skew
  input  wire logic [7:0] extEn,
  input  wire logic [7:0] extVal,
  input  wire logic [7:0] ttlFlip,
  // To the two input buffers
  output logic      [7:0] pinSchmittIn,
  output logic      [7:0] pinTtlIn
);
  logic [7:0] floatPat = 8'h55;
  logic [7:0] lvl;
  // A floating pin wanders every cycle, so nothing may rely on it
  always_ff @(posedge ref_clk) begin
    floatPat <= ~floatPat;
  end
  // Port driver first, then outside driver, then pull-up
  assign lvl = (~pinOe_n & pinOut) | (pinOe_n & extEn & extVal) | (pinOe_n & ~extEn & (pinPullup | floatPat));
  // A mid-level may resolve differently in the TTL buffer
  assign pinSchmittIn = lvl;
  assign pinTtlIn     = lvl ^ ttlFlip;
endmodule

/* gpio_pin_sync.sv */
// Two-flop synchroniser for one pin input level
`timescale 1ns/1ps
module gpio_pin_sync
  import gpio_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Level in and out
  input  wire logic pinRaw,
  output logic      pinSync
);
  logic [1:0] stage;

  // Only the second flop is read downstream, so metastability never escapes
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stage <= SYNC_RESET;
    end else begin
      stage <= {stage[0], pinRaw};
    end
  end

  assign pinSync = stage[1];
endmodule

/* gpio_pkg.sv */
// Package of constants for the bidirectional I/O port
package gpio_pkg;
  localparam int          PORT_WIDTH     = 8;
  localparam logic [7:0]  DIR_RESET      = 8'hFF;
  localparam logic [7:0]  LATCH_RESET    = 8'h00;
  localparam logic [7:0]  ANALOG_RESET   = 8'hFF;
  localparam logic [7:0]  OPEN_RESET     = 8'h00;
  localparam logic [7:0]  SLEW_RESET     = 8'hFF;
  localparam logic [7:0]  THRESH_RESET   = 8'hFF;
  localparam logic [7:0]  PULLUP_RESET   = 8'h00;
  localparam logic [7:0]  ALL_ZERO       = 8'h00;
  localparam logic [1:0]  SYNC_RESET     = 2'h0;
  localparam logic        DIR_INPUT      = 1'b1;
  localparam logic        THRESH_SCHMITT = 1'b1;
  localparam logic [2:0]  SEL_DIR        = 3'h0;
  localparam logic [2:0]  SEL_LATCH      = 3'h1;
  localparam logic [2:0]  SEL_ANALOG     = 3'h2;
  localparam logic [2:0]  SEL_OPEN       = 3'h3;
  localparam logic [2:0]  SEL_SLEW       = 3'h4;
  localparam logic [2:0]  SEL_THRESH     = 3'h5;
  localparam logic [2:0]  SEL_PULLUP     = 3'h6;
  localparam logic [2:0]  SEL_LEVEL      = 3'h7;
endpackage

/* gpio_port.sv */
// Eight-pin bidirectional general-purpose I/O port with per-pin configuration
//
// Behaviour
// R01 - Direction 1 makes pin input, driver off; 0 drives the latch value.
// R02 - Port write updates latch; port read returns actual pin levels.
// R03 - Latch read returns latch contents; latch write acts like port write.
// R04 - Latch holds most recent value written through either register.
// R05 - Analog-selected pin has input buffer off; digital reads return 0.
// R06 - Analog selection does not stop digital output driving.
// R07 - Enabled analog output beats all digital outputs, driver goes high-Z.
// R08 - After reset pin output source is latch; peripherals only via pin-select.
// R09 - Analog select resets to analog; software clears it for digital input.
// R10 - Open-drain bit makes pin sink only; clear gives push-pull.
// R11 - Slew-limit bit limits slew rate per pin; clear gives full rate.
// R12 - Per-pin threshold select governs port reads and change detection.
// R13 - Peripheral-owned pin is not general output, but stays readable.
// R14 - Direction controls drivers even for analog inputs; keep it set.
// R15 - Software changes threshold only while peripherals are disabled.
// R16 - Each pin has a weak pull-up enabled by its own bit.
// R17 - I2C ownership forces open-drain regardless of the open-drain bit.
// R18 - Eight bidirectional pins, each with own direction, latch, config.
// R19 - Analog inputs stay connected to the pin regardless of analog select.
// R20 - Threshold bit 1 selects Schmitt, 0 selects TTL.
// R21 - Pull-up disabled automatically while the pin is an output. Code gates it on the direction bit only; peripheral-driven pins keep it.
// R22 - Pin levels are synchronised to the clock before the read path.
`timescale 1ns/1ps
module gpio_port
  import gpio_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // Software register access
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [2:0]            regSel,
  input  wire logic [PORT_WIDTH-1:0] regWdata,
  output logic      [PORT_WIDTH-1:0] regRdata,
  // Peripheral and analog overrides
  input  wire logic [PORT_WIDTH-1:0] periphSelect,
  input  wire logic [PORT_WIDTH-1:0] periphOut,
  input  wire logic [PORT_WIDTH-1:0] periphDriveEnable,
  input  wire logic [PORT_WIDTH-1:0] i2cOwn,
  input  wire logic [PORT_WIDTH-1:0] analogOutEnable,
  // Pin levels as seen by the two input buffers
  input  wire logic [PORT_WIDTH-1:0] pinSchmittIn,
  input  wire logic [PORT_WIDTH-1:0] pinTtlIn,
  // Pad controls
  output logic      [PORT_WIDTH-1:0] pinOut,
  output logic      [PORT_WIDTH-1:0] pinOe_n,
  output logic      [PORT_WIDTH-1:0] pinSlewLimit,
  output logic      [PORT_WIDTH-1:0] pinPullup,
  output logic      [PORT_WIDTH-1:0] pinInputBufEnable,
  output logic      [PORT_WIDTH-1:0] pinAnalogConnect,
  // Synchronised digital inputs for peripherals and change detection
  output logic      [PORT_WIDTH-1:0] pinDigitalIn
);

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  logic [PORT_WIDTH-1:0] pinDirection; // [R18] one bit per pin in every register
  logic [PORT_WIDTH-1:0] outputLatch;
  logic [PORT_WIDTH-1:0] analogSelect;
  logic [PORT_WIDTH-1:0] openDrainSelect;
  logic [PORT_WIDTH-1:0] slewLimitSelect;
  logic [PORT_WIDTH-1:0] inputThresholdSelect;
  logic [PORT_WIDTH-1:0] pullupSelect;

  // ==========================================================================
  // Register select decode
  // ==========================================================================
  // One named select per register, shared by the write and read paths
  wire selDir    = (regSel == SEL_DIR);
  wire selLatch  = (regSel == SEL_LATCH);
  wire selAnalog = (regSel == SEL_ANALOG);
  wire selOpen   = (regSel == SEL_OPEN);
  wire selSlew   = (regSel == SEL_SLEW);
  wire selThresh = (regSel == SEL_THRESH);
  wire selPullup = (regSel == SEL_PULLUP);
  wire selLevel  = (regSel == SEL_LEVEL);

  // Write strobes; a write to the level register lands in the latch
  wire wrDir    = regWrite && selDir;
  wire wrLatch  = regWrite && (selLatch || selLevel); // [R02] [R03] [R04]
  wire wrAnalog = regWrite && selAnalog;
  wire wrOpen   = regWrite && selOpen;
  wire wrSlew   = regWrite && selSlew;
  wire wrThresh = regWrite && selThresh;
  wire wrPullup = regWrite && selPullup;

  // ==========================================================================
  // Configuration storage
  // ==========================================================================
  // Direction resets to input so no pin drives before software decides
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinDirection <= DIR_RESET;
    end else if (wrDir) begin
      pinDirection <= regWdata;
    end
  end

  // Single latch shared by both write paths, last write wins
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      outputLatch <= LATCH_RESET;
    end else if (wrLatch) begin
      outputLatch <= regWdata; // [R04]
    end
  end

  // Analog select powers up in analog mode
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      analogSelect <= ANALOG_RESET; // [R09]
    end else if (wrAnalog) begin
      analogSelect <= regWdata;
    end
  end

  // Open-drain select, one bit per pin
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      openDrainSelect <= OPEN_RESET;
    end else if (wrOpen) begin
      openDrainSelect <= regWdata;
    end
  end

  // Slew-rate limit select, one bit per pin
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      slewLimitSelect <= SLEW_RESET;
    end else if (wrSlew) begin
      slewLimitSelect <= regWdata;
    end
  end

  // Threshold select; changing it live may glitch peripherals, software's job
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      inputThresholdSelect <= THRESH_RESET;
    end else if (wrThresh) begin
      inputThresholdSelect <= regWdata; // [R15]
    end
  end

  // Weak pull-up select, one bit per pin
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pullupSelect <= PULLUP_RESET;
    end else if (wrPullup) begin
      pullupSelect <= regWdata;
    end
  end

  // ==========================================================================
  // Input path
  // ==========================================================================
  logic [PORT_WIDTH-1:0] schmittSync;
  logic [PORT_WIDTH-1:0] ttlSync;

  // Both buffers are synchronised so the selector never sees a metastable bit
  genvar gi;
  generate
    for (gi = 0; gi < PORT_WIDTH; gi++) begin : g_sync
      gpio_pin_sync u_schmitt (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pinRaw  (pinSchmittIn[gi]),
        .pinSync (schmittSync[gi])
      ); // [R22]
      gpio_pin_sync u_ttl (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pinRaw  (pinTtlIn[gi]),
        .pinSync (ttlSync[gi])
      ); // [R22]
    end
  endgenerate

  // Threshold choice then analog masking; peripheral pins still read back
  wire [PORT_WIDTH-1:0] threshLevel =
    (inputThresholdSelect & schmittSync) | (~inputThresholdSelect & ttlSync); // [R12] [R20]
  wire [PORT_WIDTH-1:0] levelRead = threshLevel & ~analogSelect; // [R05] [R13]

  // ==========================================================================
  // Output path
  // ==========================================================================
  // Peripheral data only reaches a pin when the pin-select routes it there
  wire [PORT_WIDTH-1:0] dataSrc   = (periphSelect & periphOut) | (~periphSelect & outputLatch); // [R08] [R13]
  // A routed peripheral decides its own drive; the port latch loses the pin
  wire [PORT_WIDTH-1:0] periphDrive = periphSelect & periphDriveEnable; // [R13]
  // Direction bit set means input, so port pins drive on its inverse
  wire [PORT_WIDTH-1:0] pinIsOutput = pinDirection ^ {PORT_WIDTH{DIR_INPUT}};
  wire [PORT_WIDTH-1:0] portDrive   = ~periphSelect & pinIsOutput; // [R01] [R14]
  wire [PORT_WIDTH-1:0] driveReq    = periphDrive | portDrive;
  // Analog select is not a term here: digital output survives it
  wire [PORT_WIDTH-1:0] driveOk   = driveReq & ~analogOutEnable; // [R06] [R07]
  wire [PORT_WIDTH-1:0] openDrain = openDrainSelect | i2cOwn; // [R10] [R17]
  // Open drain only enables the driver while pulling low
  wire [PORT_WIDTH-1:0] next_oe   = driveOk & ~(openDrain & dataSrc); // [R10]
  // Open-drain pads never see a one, so a stray enable cannot source current
  wire [PORT_WIDTH-1:0] next_out  = dataSrc & ~openDrain; // [R01] [R10]
  // Pull-up off whenever the direction bit marks an output; a peripheral driving the pin leaves it on
  wire [PORT_WIDTH-1:0] next_pull = pullupSelect & pinDirection; // [R16] [R21]

  // Read data select: level register reads pins, all others read back storage
  wire [PORT_WIDTH-1:0] next_rdata =
    ({PORT_WIDTH{selDir}}    & pinDirection)         |
    ({PORT_WIDTH{selLatch}}  & outputLatch)          | // [R03]
    ({PORT_WIDTH{selAnalog}} & analogSelect)         |
    ({PORT_WIDTH{selOpen}}   & openDrainSelect)      |
    ({PORT_WIDTH{selSlew}}   & slewLimitSelect)      |
    ({PORT_WIDTH{selThresh}} & inputThresholdSelect) |
    ({PORT_WIDTH{selPullup}} & pullupSelect)         |
    ({PORT_WIDTH{selLevel}}  & levelRead); // [R02]

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  // Read data is captured on the read strobe and held until the next read
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      regRdata <= ALL_ZERO;
    end else if (regRead) begin
      regRdata <= next_rdata;
    end
  end

  // Pad controls cost one cycle of latency but come straight from flops
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinOut <= ALL_ZERO;
    end else begin
      pinOut <= next_out; // [R01] [R10]
    end
  end

  // Output enable, active low; reset keeps every driver off
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinOe_n <= {PORT_WIDTH{DIR_INPUT}};
    end else begin
      pinOe_n <= ~next_oe; // [R01] [R07]
    end
  end

  // Slew limit follows its select bit one cycle later
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinSlewLimit <= SLEW_RESET;
    end else begin
      pinSlewLimit <= slewLimitSelect; // [R11]
    end
  end

  // Weak pull-up, already gated off for pins whose direction bit is output
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinPullup <= PULLUP_RESET;
    end else begin
      pinPullup <= next_pull; // [R16] [R21]
    end
  end

  // Input buffer off on analog pins, sparing it the mid-level current
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinInputBufEnable <= ALL_ZERO;
    end else begin
      pinInputBufEnable <= ~analogSelect; // [R05]
    end
  end

  // Analog inputs are never cut off; the flop only keeps outputs registered
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinAnalogConnect <= {PORT_WIDTH{1'b1}};
    end else begin
      pinAnalogConnect <= {PORT_WIDTH{1'b1}}; // [R19]
    end
  end

  // Level for peripherals and change detection, same view as port reads
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinDigitalIn <= ALL_ZERO;
    end else begin
      pinDigitalIn <= levelRead; // [R12]
    end
  end

endmodule

/* gpio_port_monitor.sv */
// Assertion checker on the I/O port boundary
`timescale 1ns/1ps
module gpio_port_monitor
  import gpio_pkg::*;
(
  // Clock and register side
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [2:0] regSel,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // Overrides
  input wire logic [7:0] periphSelect,
  input wire logic [7:0] i2cOwn,
  input wire logic [7:0] analogOutEnable,
  // Pad side
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe_n,
  input wire logic [7:0] pinSlewLimit,
  input wire logic [7:0] pinPullup,
  input wire logic [7:0] pinInputBufEnable,
  input wire logic [7:0] pinAnalogConnect
);
  // ==========================================
  // Checks; overrides are looked at two deep since pads may be registered once or twice
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_analog_connect: assert property (pinAnalogConnect == 8'hFF)
    else $error("analog inputs cut off");
  a_reset_pads: assert property (disable iff (1'b0) !resetn |=> ##1
    pinOe_n == 8'hFF && pinPullup == 8'h00 && pinInputBufEnable == 8'h00) else $error("pads not at reset state");
  a_analog_out_hiz: assert property (
    (($past(analogOutEnable) & $past(analogOutEnable, 2)) & ~pinOe_n) == 8'h00)
    else $error("driver on under analog output");
  a_pullup_input: assert property (
    (pinPullup & ~pinOe_n & ~$past(periphSelect) & ~$past(periphSelect, 2)) == 8'h00)
    else $error("pull-up on a driven pin");
  a_analog_reads_zero: assert property (
    regRead && regSel == SEL_LEVEL |=> (regRdata & ~pinInputBufEnable) == 8'h00)
    else $error("analog pin read as one");
  a_latch_readback: assert property (regWrite && (regSel == SEL_LATCH || regSel == SEL_LEVEL) ##1
    regRead && !regWrite && regSel == SEL_LATCH |=> regRdata == $past(regWdata, 2)) else $error("latch readback");
  a_i2c_open_drain: assert property ((($past(i2cOwn) & $past(i2cOwn, 2)) & pinOut) == 8'h00)
    else $error("I2C pin driven high");
  a_slew_follows: assert property (regWrite && regSel == SEL_SLEW |=> ##1 pinSlewLimit == $past(regWdata, 2))
    else $error("slew select not on pad");
endmodule

/* tb_gpio_port.sv */
// Random and corner-case bench for the I/O port
`timescale 1ns/1ps
module tb_gpio_port
  import gpio_pkg::*;
;
  logic       ref_clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [2:0] regSel = 3'h0;
  logic [7:0] regWdata = 8'h00, ps = 8'h00, po = 8'h00, pde = 8'h00, i2c = 8'h00, aoe = 8'h00;
  logic [7:0] extEn = 8'h00, extVal = 8'h00, flip = 8'h00;
  logic [7:0] regRdata, sch, ttl, pinOut, pinOe_n, slew, pu, ibe, acon, din;
  logic [7:0] dir, lat, an, od, sl, thr, wpu, drv, dat, eoe, eout, lvl, ein;
  logic [7:0] rst [7] = '{DIR_RESET, LATCH_RESET, ANALOG_RESET, OPEN_RESET, SLEW_RESET, THRESH_RESET, PULLUP_RESET};
  int         fails = 0, n_tests = 0, cycles = 0;
  gpio_port DUT (.ref_clk, .resetn, .regWrite, .regRead, .regSel, .regWdata, .regRdata, .periphSelect(ps),
    .periphOut(po), .periphDriveEnable(pde), .i2cOwn(i2c), .analogOutEnable(aoe), .pinSchmittIn(sch), .pinTtlIn(ttl),
    .pinOut, .pinOe_n, .pinSlewLimit(slew), .pinPullup(pu), .pinInputBufEnable(ibe), .pinAnalogConnect(acon),
    .pinDigitalIn(din));
  gpio_pin_model PINS (.ref_clk, .pinOut, .pinOe_n, .pinPullup(pu), .extEn, .extVal, .ttlFlip(flip),
    .pinSchmittIn(sch), .pinTtlIn(ttl));
  initial forever #10 ref_clk = ~ref_clk;
  // Bus helpers, entered and left at a falling edge
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes stay up on return so back-to-back calls never drop and raise in one step
  task automatic wr(logic [2:0] sel, logic [7:0] d);
    regRead = 1'b0;
    regWrite = 1'b1;
    regSel = sel;
    regWdata = d;
    @(negedge ref_clk);
  endtask
  task automatic rd(logic [2:0] sel);
    regWrite = 1'b0;
    regRead = 1'b1;
    regSel = sel;
    @(negedge ref_clk);
  endtask
  function automatic logic [7:0] rnd();
    return 8'($urandom);
  endfunction
  // Pad state and pin level that the settings should give
  function automatic void predict();
    drv = (ps & pde) | (~ps & ~dir);
    dat = (ps & po) | (~ps & lat);
    eoe = ~drv | aoe | ((od | i2c) & dat);
    eout = dat & ~(od | i2c);
    lvl = (~eoe & eout) | (eoe & ((extEn & extVal) | ~extEn));
    ein = ((thr & lvl) | (~thr & (lvl ^ flip))) & ~an;
  endfunction
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard, far above the forty rounds of sixteen cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'hc5a6576b));
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(3'(i));
      cmp("reset value", rst[i], regRdata);
    end
    cmp("reset oe", DIR_RESET, pinOe_n);
    for (int k = 0; k < 40; k++) begin
      {ps, i2c} = 16'h0000;
      thr = rnd();
      wr(SEL_THRESH, thr);
      {dir, lat, an, od, sl, wpu} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      {ps, po, pde, i2c, aoe, extVal, flip} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      if (k == 0) {dir, an, ps, i2c, aoe} = {ALL_ZERO, 8'hFF, 24'h00_0000};
      extEn = ~(wpu & dir);
      wr(k[0] ? SEL_LEVEL : SEL_LATCH, ~lat);
      wr(k[0] ? SEL_LATCH : SEL_LEVEL, lat);
      rd(SEL_LATCH);
      cmp("latch", lat, regRdata);
      wr(SEL_DIR, dir);
      wr(SEL_ANALOG, an);
      wr(SEL_OPEN, od);
      wr(SEL_SLEW, sl);
      wr(SEL_PULLUP, wpu);
      regWrite = 1'b0;
      repeat (5) @(negedge ref_clk);
      predict();
      cmp("oe", eoe, pinOe_n);
      cmp("out", eout, pinOut);
      cmp("slew", sl, slew);
      cmp("pullup", wpu & dir, pu);
      cmp("bufen", ~an, ibe);
      cmp("analog", 8'hFF, acon);
      cmp("din", ein, din);
      rd(SEL_LEVEL);
      cmp("level", ein, regRdata);
      rd(SEL_DIR);
      cmp("dir", dir, regRdata);
    end
    end_sim();
  end
endmodule
bind gpio_port gpio_port_monitor MON (.ref_clk, .resetn, .regWrite, .regRead, .regSel, .regWdata, .regRdata,
  .periphSelect, .i2cOwn, .analogOutEnable, .pinOut, .pinOe_n, .pinSlewLimit, .pinPullup, .pinInputBufEnable,
  .pinAnalogConnect);
